// *** rtl/onchip_data_ram_pkg.sv ***
// Constants for the on-chip data RAM page decoder
package onchip_data_ram_pkg;
  localparam int unsigned RAM_BYTES = 2048;
  localparam int unsigned RAM_AW = 11;
  localparam logic [7:0] PAGE_SELECT_ADDR = 8'haa;
  localparam logic [7:0] PAGE_SELECT_RESET = 8'h00;
  localparam int unsigned PAGE_FIELD_W = 3;
  localparam logic [10:0] USER_LAST = 11'h3ff;
  localparam logic [10:0] FIFO_FIRST = 11'h400;
  localparam logic [10:0] FIFO_LAST = 11'h7ff;
  localparam int unsigned USER_WAIT = 0;
  localparam int unsigned FIFO_WAIT = 2;
endpackage

// *** rtl/onchip_data_ram_page_decoder.sv ***
// External-data RAM array with page select and region timing
`timescale 1ns/10ps
`default_nettype none
module onchip_data_ram_page_decoder
  import onchip_data_ram_pkg::*;
#(
  parameter int unsigned FIFO_EXTRA = FIFO_WAIT
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic move_req,
  input wire logic move_write,
  input wire logic move_short,
  input wire logic [15:0] wide_data_pointer,
  input wire logic [7:0] short_addr,
  input wire logic [7:0] move_wdata,
  input wire logic flash_write_sel,
  input wire logic usb_clk_active,
  output logic move_busy,
  output logic move_done,
  output logic move_fault,
  output logic [7:0] move_rdata
);

  // ----------------------------------------
  // Page-select register
  // ----------------------------------------
  logic [PAGE_FIELD_W-1:0] page_field;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      page_field <= PAGE_SELECT_RESET[PAGE_FIELD_W-1:0];
    end else if (sfr_wr && sfr_addr == PAGE_SELECT_ADDR) begin
      page_field <= sfr_wdata[PAGE_FIELD_W-1:0];
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_rd && sfr_addr == PAGE_SELECT_ADDR) begin
      sfr_rdata <= {5'h00, page_field};
    end else begin
      sfr_rdata <= 8'h00;
    end
  end

  // ----------------------------------------
  // Address formation
  // ----------------------------------------
  logic [15:0] full_addr;
  logic [RAM_AW-1:0] ram_addr;
  logic in_fifo;

  always_comb begin
    if (move_short) begin
      full_addr = {5'h00, page_field, short_addr};
    end else begin
      full_addr = wide_data_pointer;
    end
    ram_addr = full_addr[RAM_AW-1:0];
    in_fifo = (ram_addr >= FIFO_FIRST) && (ram_addr <= FIFO_LAST);
  end

  // ----------------------------------------
  // Access sequencer
  // ----------------------------------------
  typedef enum logic [1:0] {IDLE, WAIT, DONE} move_state_e;
  move_state_e state;
  move_state_e next_state;
  logic [1:0] wait_cnt;
  logic [1:0] next_wait_cnt;
  logic [RAM_AW-1:0] held_addr;
  logic held_write;
  logic [7:0] held_data;
  logic [7:0] ram [RAM_BYTES];
  logic accept;
  logic wait_over;

  assign accept = move_req && !flash_write_sel && state == IDLE;
  assign move_busy = state != IDLE;
  assign wait_over = wait_cnt <= 2'h1;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      IDLE: begin
        if (accept && in_fifo) begin
          next_state = WAIT;
        end else if (accept) begin
          next_state = DONE;
        end
      end
      WAIT: begin
        if (wait_over) begin
          next_state = DONE;
        end
      end
      DONE: begin
        next_state = IDLE;
      end
      default: begin
        next_state = IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state <= IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------
  // Endpoint-area wait counter
  // ----------------------------------------
  always_comb begin
    next_wait_cnt = wait_cnt;
    if (accept && in_fifo) begin
      next_wait_cnt = 2'(FIFO_EXTRA);
    end else if (state == WAIT && !wait_over) begin
      next_wait_cnt = wait_cnt - 2'h1;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wait_cnt <= 2'h0;
    end else begin
      wait_cnt <= next_wait_cnt;
    end
  end

  // ----------------------------------------
  // Request capture
  // ----------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      held_addr <= '0;
    end else if (accept) begin
      held_addr <= ram_addr;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      held_write <= 1'b0;
    end else if (accept) begin
      held_write <= move_write;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      held_data <= 8'h00;
    end else if (accept) begin
      held_data <= move_wdata;
    end
  end

  // ----------------------------------------
  // Array access, endpoint region only while usb_clk_active
  // ----------------------------------------
  logic fifo_held;
  logic can_access;
  assign fifo_held = held_addr > USER_LAST;
  assign can_access = !fifo_held || usb_clk_active;

  always_ff @(posedge core_clk) begin
    if (state == DONE && held_write && can_access) begin
      ram[held_addr] <= held_data;
    end
  end

  // ----------------------------------------
  // Completion outputs
  // ----------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      move_done <= 1'b0;
    end else begin
      move_done <= state == DONE;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      move_fault <= 1'b0;
    end else begin
      move_fault <= state == DONE && !can_access;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      move_rdata <= 8'h00;
    end else if (state == DONE && !held_write) begin
      if (can_access) begin
        move_rdata <= ram[held_addr];
      end else begin
        move_rdata <= 8'h00;
      end
    end
  end

endmodule
`default_nettype wire

// *** testbench/onchip_data_ram_page_decoder_monitor.sv ***
// Port checks for the page decoder
`timescale 1ns/10ps
`default_nettype none
module onchip_data_ram_page_decoder_monitor (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic move_req,
  input wire logic move_busy,
  input wire logic move_done,
  input wire logic move_fault,
  input wire logic flash_write_sel,
  input wire logic usb_clk_active,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_rdata
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  page_top_a: assert property (sfr_rdata[7:3] == 5'h00)
    else $error("page top bits set");
  move_time_a: assert property (move_req && !move_busy && !flash_write_sel
    |-> ##[2:5] move_done) else $error("move not done");
  flash_hold_a: assert property (flash_write_sel && !move_busy
    |=> !move_busy) else $error("move taken in flash mode");
  fault_pair_a: assert property (move_fault |-> move_done)
    else $error("fault without done");
  done_pulse_a: assert property (move_done |=> !move_done)
    else $error("done longer than one cycle");
  fault_clock_a: assert property (move_fault |-> !$past(usb_clk_active))
    else $error("fault with clock running");
  page_idle_a: assert property (!$past(sfr_rd) |-> sfr_rdata == 8'h00)
    else $error("read data without read");
endmodule
bind onchip_data_ram_page_decoder onchip_data_ram_page_decoder_monitor i_mon (.*);
`default_nettype wire

// *** testbench/onchip_data_ram_core_model.sv ***
// Processor-side model issuing data moves
`timescale 1ns/10ps
`default_nettype none
module onchip_data_ram_core_model (input wire logic core_clk, move_done,
  input wire logic [7:0] move_rdata,
  output logic move_req = '0, move_write = '0, move_short = '0,
  output logic [15:0] wide_data_pointer = '0,
  output logic [7:0] short_addr = '0, move_wdata = '0);
  // Wide or paged (move_short) moves to any address, endpoint area included
  task automatic mv(logic w, s, logic [15:0] a, logic [7:0] d,
    output logic [7:0] q, output int n);
    @(posedge core_clk);
    {move_req, move_write, move_short, wide_data_pointer} <= {1'b1, w, s, a};
    {short_addr, move_wdata} <= {a[7:0], d};
    @(posedge core_clk);
    {move_req, wide_data_pointer, short_addr} <= {1'b0, ~a, ~a[7:0]};
    n = 0;
    do @(posedge core_clk); while (!move_done && ++n < 9);
    q = move_rdata;
  endtask
endmodule
`default_nettype wire

// *** testbench/test_onchip_data_ram_page_decoder.sv ***
// Bench for the page decoder
`timescale 1ns/10ps
`default_nettype none
module test_onchip_data_ram_page_decoder;
  import onchip_data_ram_pkg::*;
  logic core_clk = 0, rst = 1, sfr_wr = 0, sfr_rd = 0, flash_write_sel = 0;
  logic usb_clk_active = 1, move_req, move_write, move_short, move_busy;
  logic move_done, move_fault;
  logic [7:0] sfr_addr = 8'haa, sfr_wdata = '0, sfr_rdata, short_addr, q;
  logic [7:0] move_wdata, move_rdata;
  logic [15:0] wide_data_pointer;
  logic [31:0] s = 32'h0f354e58;
  int errors = 0, n_checks = 0, n, m;
  onchip_data_ram_page_decoder i_dut (.*);
  onchip_data_ram_core_model i_core (.*);
  function automatic logic [31:0] xs(logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction
  task automatic chk(logic [7:0] g, e);
    n_checks++;
    if (g !== e) errors++;
    if (g !== e) $display("CHECK FAILED %0t %h %h", $time, g, e);
  endtask
  task automatic tally_and_finish(int late);
    errors += late;
    $display("%0d checks %0d errors", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial forever #25 core_clk = ~core_clk;
  initial #200000 tally_and_finish(1);
  initial begin
    repeat (20) @(posedge core_clk);
    rst <= 0;
    @(posedge core_clk) {sfr_wr, sfr_wdata} <= {1'b1, 8'hfd};
    @(posedge core_clk) {sfr_wr, sfr_rd} <= 2'h1;
    @(posedge core_clk) sfr_rd <= 0;
    @(posedge core_clk) chk(sfr_rdata, 8'h05);
    i_core.mv(1, 0, 16'h05c3, 8'ha6, q, n);
    i_core.mv(0, 1, 16'hffc3, 8'h00, q, n);
    chk(q, 8'ha6);
    repeat (8) begin
      s = xs(s);
      i_core.mv(1, 0, s[15:0], s[23:16], q, m);
      i_core.mv(0, 0, s[15:0] ^ {s[31:27], 11'h0}, 8'h00, q, n);
      chk(q, s[23:16]);
    end
    i_core.mv(1, 0, 16'h0010, 8'h00, q, m);
    i_core.mv(1, 0, 16'h0420, 8'h22, q, n);
    chk(8'(n), 8'(m + FIFO_WAIT));
    flash_write_sel <= 1;
    i_core.mv(1, 0, 16'h0420, 8'h11, q, n);
    chk(8'(n), 8'h09);
    {flash_write_sel, usb_clk_active} <= 2'h0;
    i_core.mv(0, 0, 16'h0420, 8'h00, q, n);
    chk(q, 8'h00);
    tally_and_finish(0);
  end
endmodule
`default_nettype wire
